// [hdl/vco_cfg_pkg.sv]
// constants for the oscillator subsystem indirect configuration registers
// assumes a single 100 MHz clock domain and a parallel write of the port word
package vco_cfg_pkg;
  localparam logic [7:0] INDIRECT_PORT_OFFSET = 8'h05;
  localparam int         PORT_WIDTH           = 17;
  localparam int         SEL_LSB              = 0;
  localparam int         SEL_MSB              = 2;
  localparam int         ADDR_LSB             = 3;
  localparam int         ADDR_MSB             = 6;
  localparam int         DATA_LSB             = 7;
  localparam int         DATA_MSB             = 15;
  localparam int         SUB_WIDTH            = 9;
  localparam logic [2:0] OSC_SUBSYSTEM_ID     = 3'h0;

  // subsystem register addresses
  localparam logic [3:0] SUB_ENABLE_ADDR      = 4'h1;
  localparam logic [3:0] SUB_DIVIDE_ADDR      = 4'h2;
  localparam logic [3:0] SUB_CONFIG_ADDR      = 4'h3;

  // reset values
  localparam logic [8:0] ENABLE_RESET         = 9'h1FF;
  localparam logic [8:0] DIVIDE_RESET         = 9'h001;
  localparam logic [8:0] CONFIG_RESET         = 9'h092;

  // enable register fields
  localparam int         EN_MASTER_BIT        = 0;
  localparam int         EN_OSC_BIT           = 1;
  localparam int         EN_PLL_BUF_BIT       = 2;
  localparam int         EN_IO_MASTER_BIT     = 3;
  localparam int         EN_OUT_STAGE_BIT     = 5;

  // configuration register fields
  localparam int         CFG_PERF_LSB         = 0;
  localparam int         CFG_NEG_EN_BIT       = 2;
  localparam int         CFG_POS_EN_BIT       = 3;
  localparam int         CFG_MATCH_BIT        = 5;
  localparam int         CFG_MUTE_LSB         = 7;

  // divider limits
  localparam logic [5:0] DIV_MAX              = 6'h3E;

  typedef enum logic [1:0] {
    MUTE_ON_ZERO_DIV = 2'b00,
    MUTE_DURING_CAL  = 2'b01,
    MUTE_UNSUPPORTED = 2'b10,
    MUTE_ALWAYS      = 2'b11
  } mute_mode_e;

  typedef enum logic [1:0] {
    PERF_RESV0      = 2'b00,
    PERF_LOW_CURR   = 2'b01,
    PERF_RESV2      = 2'b10,
    PERF_HIGH_PERF  = 2'b11
  } perf_mode_e;
endpackage

// [hdl/port_word_decode.sv]
// splits the indirect port word into select, address and payload
// assumes the strobe is one cycle wide and synchronous to i_clk
`timescale 1ns/100ps
`default_nettype none
module port_word_decode
  import vco_cfg_pkg::*;
(
  input  wire logic [PORT_WIDTH-1:0] i_word,
  input  wire logic                  i_strobe,
  output var  logic                  o_hit,
  output var  logic [3:0]            o_addr,
  output var  logic [SUB_WIDTH-1:0]  o_data
);
  // only subsystem zero answers; other ids belong to other subsystems
  always_comb begin
    o_hit  = i_strobe && (i_word[SEL_MSB:SEL_LSB] == OSC_SUBSYSTEM_ID);
    o_addr = i_word[ADDR_MSB:ADDR_LSB];
    o_data = i_word[DATA_MSB:DATA_LSB];
  end
endmodule
`default_nettype wire

// [hdl/divide_ratio_clamp.sv]
// maps a requested divide ratio onto the ratio the divider really uses
// purely combinational; no state
`timescale 1ns/100ps
`default_nettype none
module divide_ratio_clamp
  import vco_cfg_pkg::*;
(
  input  wire logic [5:0] i_req,
  output var  logic [5:0] o_ratio
);
  function automatic logic [5:0] clamp_ratio(input logic [5:0] r);
    logic [5:0] v;
    v = r;
    if (v > DIV_MAX) begin
      v = DIV_MAX;
    end
    if (v != 6'h01) begin
      v = {v[5:1], 1'b0};            // odd rounds down to even
    end
    return v;
  endfunction

  always_comb begin
    o_ratio = clamp_ratio(i_req);
  end
endmodule
`default_nettype wire

// [hdl/vco_indirect_config_regs.sv]
// write-only oscillator subsystem registers reached via the indirect port
// assumes the main register file raises i_port_wr for one cycle per write
`timescale 1ns/100ps
`default_nettype none
module vco_indirect_config_regs
  import vco_cfg_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_port_wr,
  input  wire logic [7:0]            i_port_offset,
  input  wire logic [PORT_WIDTH-1:0] i_port_wdata,
  input  wire logic                  i_cal_busy,
  output logic                       o_sub_enable,
  output logic                       o_osc_enable,
  output logic                       o_pll_buf_enable,
  output logic                       o_io_enable,
  output logic                       o_out_stage_enable,
  output logic [5:0]                 o_divide_ratio,
  output logic [1:0]                 o_perf_mode,
  output logic                       o_neg_out_enable,
  output logic                       o_pos_out_enable,
  output logic                       o_match_select,
  output logic                       o_muted
);
  // reset release through two flops; async assert, sync release
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic rst_n;
  assign rst_n = rst_sync_q;

  // indirect decode; the window only exists behind offset 0x05
  logic                 port_sel;
  logic                 hit;
  logic [3:0]           sub_addr;
  logic [SUB_WIDTH-1:0] sub_data;
  assign port_sel = i_port_wr && (i_port_offset == INDIRECT_PORT_OFFSET);

  port_word_decode u_decode (
    .i_word   (i_port_wdata),
    .i_strobe (port_sel),
    .o_hit    (hit),
    .o_addr   (sub_addr),
    .o_data   (sub_data)
  );

  // register file state; no read path exists, so contents never leave
  logic [SUB_WIDTH-1:0] enable_q;
  logic [SUB_WIDTH-1:0] enable_d;
  logic [SUB_WIDTH-1:0] divide_q;
  logic [SUB_WIDTH-1:0] divide_d;
  logic [SUB_WIDTH-1:0] config_q;
  logic [SUB_WIDTH-1:0] config_d;

  // route payload to the addressed register; unknown addresses are dropped
  always_comb begin
    enable_d = enable_q;
    divide_d = divide_q;
    config_d = config_q;
    if (hit) begin
      case (sub_addr)
        SUB_ENABLE_ADDR: begin
          enable_d = sub_data;
        end
        SUB_DIVIDE_ADDR: begin
          divide_d = sub_data;
        end
        SUB_CONFIG_ADDR: begin
          config_d = sub_data;
        end
        default: begin
          enable_d = enable_q;
        end
      endcase
    end
  end

  // reset values put the divider at 1 and mute mode at calibration
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= ENABLE_RESET;
      divide_q <= DIVIDE_RESET;
      config_q <= CONFIG_RESET;
    end else begin
      enable_q <= enable_d;
      divide_q <= divide_d;
      config_q <= config_d;
    end
  end

  // effective ratio after clamping invalid requests
  logic [5:0] ratio_eff;
  divide_ratio_clamp u_clamp (
    .i_req   (divide_q[5:0]),
    .o_ratio (ratio_eff)
  );

  // derived control levels; registered so every output is a flop
  logic       master;
  mute_mode_e mute_mode;
  logic       mute_d;
  logic       sub_en_d;
  logic       osc_en_d;
  logic       pll_en_d;
  logic       io_en_d;
  logic       out_en_d;
  logic       neg_en_d;
  logic       pos_en_d;
  logic       match_d;
  logic [1:0] perf_d;
  logic [5:0] ratio_d;
  always_comb begin
    master    = enable_q[EN_MASTER_BIT];
    mute_mode = mute_mode_e'(config_q[CFG_MUTE_LSB +: 2]);
    // master bit overrides every other enable-register bit
    sub_en_d  = master;
    osc_en_d  = master && enable_q[EN_OSC_BIT];
    pll_en_d  = master && enable_q[EN_PLL_BUF_BIT];
    io_en_d   = master && enable_q[EN_IO_MASTER_BIT];
    out_en_d  = master && enable_q[EN_IO_MASTER_BIT] && enable_q[EN_OUT_STAGE_BIT];
    neg_en_d  = config_q[CFG_NEG_EN_BIT];
    pos_en_d  = config_q[CFG_POS_EN_BIT];
    match_d   = config_q[CFG_MATCH_BIT];
    perf_d    = config_q[CFG_PERF_LSB +: 2];
    ratio_d   = ratio_eff;
    case (mute_mode)
      MUTE_ON_ZERO_DIV: begin
        mute_d = (divide_q[5:0] == 6'h00);
      end
      MUTE_DURING_CAL: begin
        mute_d = i_cal_busy;
      end
      MUTE_ALWAYS: begin
        mute_d = 1'b1;
      end
      default: begin
        mute_d = 1'b1;     // unsupported setting: fail safe, keep quiet
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sub_enable       <= 1'b1;
      o_osc_enable       <= 1'b1;
      o_pll_buf_enable   <= 1'b1;
      o_io_enable        <= 1'b1;
      o_out_stage_enable <= 1'b1;
      o_divide_ratio     <= 6'h01;
      o_perf_mode        <= 2'h2;
      o_neg_out_enable   <= 1'b0;
      o_pos_out_enable   <= 1'b0;
      o_match_select     <= 1'b0;
      o_muted            <= 1'b0;
    end else begin
      o_sub_enable       <= sub_en_d;
      o_osc_enable       <= osc_en_d;
      o_pll_buf_enable   <= pll_en_d;
      o_io_enable        <= io_en_d;
      o_out_stage_enable <= out_en_d;
      o_divide_ratio     <= ratio_d;
      o_perf_mode        <= perf_d;
      o_neg_out_enable   <= neg_en_d;
      o_pos_out_enable   <= pos_en_d;
      o_match_select     <= match_d;
      o_muted            <= mute_d;
    end
  end
endmodule
`default_nettype wire

// [test/host_model.sv]
// host side: main register file issuing one-cycle port writes
// assumes the bench calls wr from its main process
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        i_clk,
  output var  logic        o_wr,
  output var  logic [7:0]  o_off,
  output var  logic [16:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_off = 8'h00;
    o_wdata = 17'h00000;
  end
  // one-cycle strobe at the falling edge; offset chosen by caller
  task automatic wr(input logic [7:0] off, input logic [16:0] w);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_off = off;
    o_wdata = w;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_off = ~off;
    o_wdata = ~w; // released lines carry junk so stale data is never trusted
  endtask
endmodule
`default_nettype wire

// [test/vco_cfg_checker.sv]
// assertions on the indirect configuration register block
// sees only the block's ports; bound after the module
`timescale 1ns/100ps
`default_nettype none
module vco_cfg_checker
  import vco_cfg_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_port_wr,
  input wire logic [7:0]            i_port_offset,
  input wire logic [PORT_WIDTH-1:0] i_port_wdata,
  input wire logic                  i_cal_busy,
  input wire logic                  o_sub_enable,
  input wire logic                  o_osc_enable,
  input wire logic                  o_out_stage_enable,
  input wire logic [5:0]            o_divide_ratio,
  input wire logic [1:0]            o_perf_mode,
  input wire logic                  o_neg_out_enable,
  input wire logic                  o_pos_out_enable,
  input wire logic                  o_match_select,
  input wire logic                  o_muted
);
  logic        hit, div_hit, cfg_hit, en_hit;
  logic [16:0] p_q [3];
  logic [1:0]  mode_q;
  logic [5:0]  raw_q;
  logic [2:0]  quiet_q;
  assign hit = i_port_wr && i_port_offset == INDIRECT_PORT_OFFSET && i_port_wdata[2:0] == 3'h0;
  assign div_hit = hit && i_port_wdata[6:3] == SUB_DIVIDE_ADDR;
  assign cfg_hit = hit && i_port_wdata[6:3] == SUB_CONFIG_ADDR;
  assign en_hit = hit && i_port_wdata[6:3] == SUB_ENABLE_ADDR;
  function automatic logic [5:0] clampr(input logic [5:0] r);
    if (r > DIV_MAX) return DIV_MAX;
    return (r == 6'h01) ? r : {r[5:1], 1'b0};
  endfunction
  // shadow of written fields; quiet counts edges since the last write, holding at 4
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= 2'h1;
      raw_q <= 6'h01;
      quiet_q <= 3'h0;
    end else begin
      quiet_q <= hit ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h4};
      if (div_hit) raw_q <= i_port_wdata[12:7];
      if (cfg_hit) mode_q <= i_port_wdata[15:14];
    end
  end
  // port word history, kept out of the reset flops so each flop has one style
  always_ff @(posedge i_clk) begin
    p_q[0] <= i_port_wdata;
    p_q[1] <= p_q[0];
    p_q[2] <= p_q[1];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_div_write: assert property (div_hit |-> ##3
    o_divide_ratio == clampr(p_q[2][12:7])) else $error("divide ratio wrong");
  chk_div_hold: assert property ($changed(o_divide_ratio) |->
    $past(div_hit, 2)) else $error("divide ratio moved without write");
  chk_en_stage: assert property (en_hit |-> ##3
    o_out_stage_enable == (p_q[2][7] & p_q[2][10] & p_q[2][12])) else $error("stage enable");
  chk_en_master: assert property (en_hit && !i_port_wdata[7] |-> ##3
    !(o_sub_enable | o_osc_enable | o_out_stage_enable)) else $error("master off ignored");
  chk_cfg_write: assert property (cfg_hit |-> ##3
    {o_match_select, o_pos_out_enable, o_neg_out_enable, o_perf_mode}
    == {p_q[2][12], p_q[2][10:9], p_q[2][8:7]}) else $error("config outputs wrong");
  chk_mute_zero: assert property (quiet_q == 3'h4 && mode_q == 2'h0 |->
    o_muted == (raw_q == 6'h00)) else $error("zero ratio mute wrong");
  chk_mute_cal: assert property (quiet_q == 3'h4 && mode_q == 2'h1 |->
    o_muted == $past(i_cal_busy)) else $error("calibration mute wrong");
  chk_mute_all: assert property (quiet_q == 3'h4 && mode_q == 2'h3 |->
    o_muted) else $error("unconditional mute missing");
endmodule
bind vco_indirect_config_regs vco_cfg_checker vco_cfg_checker_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_port_wr(i_port_wr), .i_port_offset(i_port_offset),
  .i_port_wdata(i_port_wdata), .i_cal_busy(i_cal_busy), .o_sub_enable(o_sub_enable),
  .o_osc_enable(o_osc_enable), .o_out_stage_enable(o_out_stage_enable),
  .o_divide_ratio(o_divide_ratio), .o_perf_mode(o_perf_mode),
  .o_neg_out_enable(o_neg_out_enable), .o_pos_out_enable(o_pos_out_enable),
  .o_match_select(o_match_select), .o_muted(o_muted));
`default_nettype wire

// [test/tb_vco_indirect_config_regs.sv]
// self-checking bench for the indirect configuration register block
// assumes host_model on the register-file side and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_vco_indirect_config_regs;
  import vco_cfg_pkg::*;
  logic        i_clk, i_rst_n, i_cal_busy, wr, muted;
  logic [7:0]  off;
  logic [16:0] wd;
  logic [4:0]  en, cf;
  logic [5:0]  ratio;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  host_model host_model_i (.i_clk(i_clk), .o_wr(wr), .o_off(off), .o_wdata(wd));
  vco_indirect_config_regs vco_indirect_config_regs_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_port_wr(wr), .i_port_offset(off),
    .i_port_wdata(wd), .i_cal_busy(i_cal_busy), .o_sub_enable(en[0]),
    .o_osc_enable(en[1]), .o_pll_buf_enable(en[2]), .o_io_enable(en[3]),
    .o_out_stage_enable(en[4]), .o_divide_ratio(ratio), .o_perf_mode(cf[1:0]),
    .o_neg_out_enable(cf[2]), .o_pos_out_enable(cf[3]), .o_match_select(cf[4]),
    .o_muted(muted));
  // clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [16:0] pw(input logic [3:0] a, input logic [8:0] d);
    return {1'b0, d, a, 3'h0};
  endfunction
  // a write then enough cycles for the outputs to settle
  task automatic put(input logic [7:0] o, input logic [16:0] w);
    host_model_i.wr(o, w);
    repeat (4) @(negedge i_clk);
  endtask
  task automatic t_reset();
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    chk({3'h0, ratio}, 9'h001);
    chk({4'h0, en}, 9'h01F);
    chk({4'h0, cf}, 9'h002);
  endtask
  task automatic t_stage();
    put(8'h05, 17'h0EF88);
    chk({4'h0, en}, 9'h00F);
    put(8'h05, pw(SUB_ENABLE_ADDR, 9'h1FE));
    chk({4'h0, en}, 9'h000);
    put(8'h05, pw(SUB_ENABLE_ADDR, ENABLE_RESET));
    chk({4'h0, en}, 9'h01F);
  endtask
  task automatic t_div();
    logic [5:0] req [7] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h3D, 6'h3E, 6'h3F};
    logic [5:0] want [7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h3C, 6'h3E, 6'h3E};
    for (int i = 0; i < 7; i++) begin
      put(8'h05, pw(SUB_DIVIDE_ADDR, {3'h0, req[i]}));
      chk({3'h0, ratio}, {3'h0, want[i]});
    end
  endtask
  task automatic t_cfg();
    logic [8:0] val [4] = '{9'h091, 9'h097, 9'h09B, 9'h0BF};
    logic [4:0] want [4] = '{5'h01, 5'h07, 5'h0B, 5'h1F};
    for (int i = 0; i < 4; i++) begin
      put(8'h05, pw(SUB_CONFIG_ADDR, val[i]));
      chk({4'h0, cf}, {4'h0, want[i]});
    end
  endtask
  // wrong offset, nonzero id, unused addresses: ratio stays at 62
  task automatic t_refuse();
    put(8'h04, pw(SUB_DIVIDE_ADDR, 9'h004));
    put(8'h05, pw(SUB_DIVIDE_ADDR, 9'h004) | 17'h00001);
    put(8'h05, pw(4'h0, 9'h004));
    put(8'h05, pw(4'h4, 9'h004));
    chk({3'h0, ratio}, 9'h03E);
  endtask
  task automatic t_mute();
    put(8'h05, pw(SUB_CONFIG_ADDR, 9'h013));
    chk({8'h00, muted}, 9'h000);
    put(8'h05, pw(SUB_DIVIDE_ADDR, 9'h000));
    chk({8'h00, muted}, 9'h001);
    put(8'h05, pw(SUB_CONFIG_ADDR, 9'h093));
    chk({8'h00, muted}, 9'h000);
    i_cal_busy = 1'b1;
    repeat (3) @(negedge i_clk);
    chk({8'h00, muted}, 9'h001);
    i_cal_busy = 1'b0;
    repeat (3) @(negedge i_clk);
    chk({8'h00, muted}, 9'h000);
    put(8'h05, pw(SUB_CONFIG_ADDR, 9'h193));
    put(8'h05, pw(SUB_DIVIDE_ADDR, 9'h001));
    chk({8'h00, muted}, 9'h001);
  endtask
  task automatic report_and_stop();
    $display("tests=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence; the closing reset checks defaults again at the end of the run
  initial begin
    i_rst_n = 1'b0;
    i_cal_busy = 1'b0;
    t_reset();
    t_stage();
    t_div();
    t_cfg();
    t_refuse();
    t_mute();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
